// File: include/cco_consts.svh
`ifndef CCO_CONSTS_SVH
`define CCO_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCO_OFF_GATE     12'h000
`define CCO_OFF_MODE     12'h004
`define CCO_OFF_STAT     12'h008

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define CCO_GATE_WMASK_M 32'hbfdf_d0ff
`define CCO_GATE_WMASK_S 32'h81df_d0ff
`define CCO_GATE_RST     32'h0100_0000
`define CCO_MODE_WMASK_M 32'hf73f_003f
`define CCO_MODE_WMASK_S 32'hf72c_0000
`define CCO_MODE_RST     32'h0000_0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCO_B_SYNC       31
`define CCO_B_STEER      24
`define CCO_B_GSM        22
`define CCO_B_AUX        19
`define CCO_B_ICS        16
`define CCO_B_RSEN       15
`define CCO_B_GM         14
`define CCO_B_SOFTWARE_SHUTDOWN       12
`define CCO_B_OUTPUT_TRIGGER_HOLD     31
`define CCO_B_OSC        28
`define CCO_B_OUTM       24
`define CCO_B_GROUP_ACE_POLARITY     21
`define CCO_B_GROUP_BDF_POLARITY     20
`define CCO_B_PSSACE     18
`define CCO_B_PSSBDF     16
`define CCO_B_TRIG       7
`define CCO_B_SHUTDOWN_ACTIVE_FLAG      4
`define CCO_B_CAPTURE_DISABLE_FLAG      2
`define CCO_B_ARM        10

// ----------------------------------------
// encodings
// ----------------------------------------
`define CCO_GSM_LEVEL    2'b00
`define CCO_GSM_RISE     2'b01
`define CCO_GSM_FALL     2'b10
`define CCO_AUX_OFF      2'b00
`define CCO_AUX_ROLL     2'b01
`define CCO_AUX_MODE     2'b10
`define CCO_AUX_EVT      2'b11
`define CCO_PSS_ACTIVE   2'b11
`define CCO_PSS_INACT    2'b10
`define CCO_ICS_PIN      3'h0
`define CCO_ICS_CMP_MAX  3'h3

`endif

// File: include/cco_pkg.sv
package cco_pkg;

	// ----------------------------------------
	// shutdown / gate sources, bit order of the source mask
	// ----------------------------------------
	typedef struct packed {
		logic       fault_pin_b;
		logic       fault_pin_a;
		logic       logic_cell;
		logic [1:0] peer;
		logic [2:0] cmp;
	} cco_gate_src_t;

	typedef enum logic [1:0] {
		CCO_OS_IDLE = 2'b01,
		CCO_OS_RUN  = 2'b10
	} cco_os_state_t;

endpackage : cco_pkg

// File: logic/cco_output_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - with sync set, steering changes wait for time-base rollover; else immediate
// - steering bit one hands the pin to the module; B..F only multi-output
// - capture gate mode: level, rising-edge enable, falling-edge disable, one reserved
// - aux output: none, rollover pulse, mode signal, capture/compare events
// - capture source: pin, comparators 1..3, logic cells 1..4
// - restart enable clears shutdown flag at next period after shutdown input ends
// - gate-mode bit defers shutdown to next time-base rollover
// - software shutdown acts like a hardware source, same timing
// - eight-bit mask picks fault pins, logic cell, peers, comparators
// - trigger-hold with triggered mode keeps pins undriven until triggered, unless shutdown state 1x drives them
// - one-shot count n stretches a trigger to n plus one periods
// - three-bit output mode field selects the output mode
// - group A/C/E polarity bit set makes outputs active low
// - group B/D/F polarity bit, multi-output only, set makes active low
// - unimplemented bits read zero and ignore writes
// - shutdown flag reads one while outputs are held in shutdown
// - shutdown state: 11 drive active, 10 drive inactive, 0x high impedance
// - capture-disable flag blocks capture events while set
// - triggered-operation enable gates the trigger-hold behaviour
`include "cco_consts.svh"

module cco_output_ctrl #(
	parameter bit MULTI   = 1'b1,
	parameter int NPINS   = 6
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  tb_rollover,
	input  wire logic                  triggered_operation_enable,
	input  wire logic                  timer_triggered,
	input  wire logic                  one_shot_trigger,
	input  wire logic                  timer_mode,
	input  wire logic                  mode_signal,
	input  wire logic                  compare_event,
	input  wire logic [NPINS-1:0]      pwm_in,
	input  wire logic                  capture_input_pin,
	input  wire logic [2:0]            cmp_in,
	input  wire logic [3:0]            clc_in,
	input  wire cco_pkg::cco_gate_src_t gate_src,
	output logic      [NPINS-1:0]      pin_steer_enables,
	output logic      [NPINS-1:0]      oc_o,
	output logic      [NPINS-1:0]      oc_oe,
	output logic                       aux_out,
	output logic                       capture_event,
	output logic                       one_shot_active,
	output logic      [2:0]            output_mode_select,
	output logic                       shutdown_active_flag,
	output logic                       capture_disable_flag
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic [2:0] dec_addr(input logic [11:0] a);
		dec_addr = {a == `CCO_OFF_STAT, a == `CCO_OFF_MODE, a == `CCO_OFF_GATE};
	endfunction : dec_addr

	localparam logic [31:0] GATE_WM = MULTI ? `CCO_GATE_WMASK_M : `CCO_GATE_WMASK_S;
	localparam logic [31:0] MODE_WM = MULTI ? `CCO_MODE_WMASK_M : `CCO_MODE_WMASK_S;

	logic [2:0]  sel;
	logic        wr;
	logic [31:0] gate_q, gate_d;
	logic [31:0] mode_q, mode_d;

	assign sel     = dec_addr(paddr);
	assign wr      = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(|sel);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_comb
	begin
		gate_d = gate_q;
		mode_d = mode_q;
		if (wr && sel[0])
			gate_d = pwdata & GATE_WM;
		if (wr && sel[1])
			mode_d = pwdata & MODE_WM;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate_q <= `CCO_GATE_RST;
			mode_q <= `CCO_MODE_RST;
		end
		else
		begin
			gate_q <= gate_d;
			mode_q <= mode_d;
		end
	end

	logic       f_sync, f_rsen, f_gm, f_software_shutdown, f_output_trigger_hold, f_group_ace_polarity, f_group_bdf_polarity;
	logic [1:0] f_gsm, f_aux, f_pssace, f_pssbdf;
	logic [2:0] f_ics, f_osc;
	logic [7:0] f_mask;

	assign f_sync   = gate_q[`CCO_B_SYNC];
	assign f_gsm    = gate_q[`CCO_B_GSM +: 2];
	assign f_aux    = gate_q[`CCO_B_AUX +: 2];
	assign f_ics    = gate_q[`CCO_B_ICS +: 3];
	assign f_rsen   = gate_q[`CCO_B_RSEN];
	assign f_gm     = gate_q[`CCO_B_GM];
	assign f_software_shutdown   = gate_q[`CCO_B_SOFTWARE_SHUTDOWN];
	assign f_mask   = gate_q[7:0];
	assign f_output_trigger_hold = mode_q[`CCO_B_OUTPUT_TRIGGER_HOLD];
	assign f_osc    = mode_q[`CCO_B_OSC +: 3];
	assign f_group_ace_polarity = mode_q[`CCO_B_GROUP_ACE_POLARITY];
	assign f_group_bdf_polarity = mode_q[`CCO_B_GROUP_BDF_POLARITY];
	assign f_pssace = mode_q[`CCO_B_PSSACE +: 2];
	assign f_pssbdf = mode_q[`CCO_B_PSSBDF +: 2];

	assign output_mode_select = mode_q[`CCO_B_OUTM +: 3];

	// ----------------------------------------
	// gating, shutdown, capture
	// ----------------------------------------
	logic [NPINS-1:0] steer_q, steer_d;
	logic        gate_raw, gate_fall, gate_rise;
	logic        geff_q, geff_d, gprev_q, gprev_d;
	logic        sd_q, sd_d, capture_disable_flag_q, capture_disable_flag_d, arm_q, arm_d;
	logic        csrc, cprev_q, cprev_d, cap_q, cap_d, aux_q, aux_d;
	logic        sw_clr_sd, sw_arm;

	assign gate_raw  = (|(f_mask & gate_src)) | f_software_shutdown;
	assign gate_rise = geff_q & ~gprev_q;
	assign gate_fall = ~geff_q & gprev_q;
	assign sw_clr_sd = wr & sel[2] & pwdata[`CCO_B_SHUTDOWN_ACTIVE_FLAG];
	assign sw_arm    = wr & sel[2] & pwdata[`CCO_B_ARM];

	always_comb
	begin
		case (f_ics)
			`CCO_ICS_PIN: csrc = capture_input_pin;
			3'h1, 3'h2, `CCO_ICS_CMP_MAX: csrc = cmp_in[f_ics[1:0] - 2'h1];
			default: csrc = clc_in[f_ics[1:0]];
		endcase
	end

	always_comb
	begin
		steer_d = steer_q;
		if (!f_sync || tb_rollover)
			steer_d = gate_q[`CCO_B_STEER +: NPINS];
		// deferred mode samples only at rollover so glitches between are ignored
		geff_d = f_gm ? (tb_rollover ? gate_raw : geff_q) : gate_raw;
		gprev_d = geff_q;
		sd_d = sd_q;
		if (sw_clr_sd)
			sd_d = 1'b0;
		if (f_rsen && tb_rollover && !geff_q)
			sd_d = 1'b0;
		if (geff_q)
			sd_d = 1'b1;
		arm_d = arm_q | sw_arm;
		capture_disable_flag_d = capture_disable_flag_q;
		case (f_gsm)
			`CCO_GSM_LEVEL: capture_disable_flag_d = ~geff_q;
			`CCO_GSM_RISE:
			begin
				if (arm_q && gate_rise)
				begin
					capture_disable_flag_d = 1'b0;
					arm_d   = sw_arm;
				end
			end
			`CCO_GSM_FALL:
			begin
				if (arm_q && gate_fall)
				begin
					capture_disable_flag_d = 1'b1;
					arm_d   = sw_arm;
				end
			end
			default: capture_disable_flag_d = capture_disable_flag_q;
		endcase
		cprev_d = csrc;
		cap_d = csrc & ~cprev_q & ~capture_disable_flag_q;
		case (f_aux)
			`CCO_AUX_ROLL: aux_d = tb_rollover;
			`CCO_AUX_MODE: aux_d = mode_signal;
			`CCO_AUX_EVT:  aux_d = ~timer_mode & (cap_q | compare_event);
			default:       aux_d = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			steer_q <= '0;
			geff_q  <= 1'b0;
			gprev_q <= 1'b0;
			sd_q    <= 1'b0;
			arm_q   <= 1'b0;
			capture_disable_flag_q <= 1'b0;
			cprev_q <= 1'b0;
			cap_q   <= 1'b0;
			aux_q   <= 1'b0;
		end
		else
		begin
			steer_q <= steer_d;
			geff_q  <= geff_d;
			gprev_q <= gprev_d;
			sd_q    <= sd_d;
			arm_q   <= arm_d;
			capture_disable_flag_q <= capture_disable_flag_d;
			cprev_q <= cprev_d;
			cap_q   <= cap_d;
			aux_q   <= aux_d;
		end
	end

	assign pin_steer_enables    = steer_q;
	assign shutdown_active_flag = sd_q;
	assign capture_disable_flag = capture_disable_flag_q;
	assign capture_event        = cap_q;
	assign aux_out              = aux_q;

	// ----------------------------------------
	// one-shot stretch
	// ----------------------------------------
	cco_pkg::cco_os_state_t os_q, os_d;
	logic [2:0] oscnt_q, oscnt_d;

	always_comb
	begin
		os_d    = os_q;
		oscnt_d = oscnt_q;
		case (os_q)
			cco_pkg::CCO_OS_IDLE:
			begin
				if (one_shot_trigger)
				begin
					os_d    = cco_pkg::CCO_OS_RUN;
					oscnt_d = f_osc;
				end
			end
			cco_pkg::CCO_OS_RUN:
			begin
				if (tb_rollover)
				begin
					if (oscnt_q == 3'h0)
						os_d = cco_pkg::CCO_OS_IDLE;
					else
						oscnt_d = oscnt_q - 3'h1;
				end
			end
			default: os_d = cco_pkg::CCO_OS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			os_q    <= cco_pkg::CCO_OS_IDLE;
			oscnt_q <= 3'h0;
		end
		else
		begin
			os_q    <= os_d;
			oscnt_q <= oscnt_d;
		end
	end

	assign one_shot_active = (os_q == cco_pkg::CCO_OS_RUN);

	// ----------------------------------------
	// pins
	// ----------------------------------------
	logic hold;

	// pins stay undriven before the trigger so the load sees no stale level
	assign hold = f_output_trigger_hold & triggered_operation_enable & ~timer_triggered;

	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++)
		begin : g_pin
			logic       pol, o_d, oe_d, o_q, oe_q;
			logic [1:0] pss;
			assign pol = (gi % 2 == 0) ? f_group_ace_polarity : f_group_bdf_polarity;
			assign pss = (gi % 2 == 0) ? f_pssace : f_pssbdf;
			always_comb
			begin
				o_d  = pwm_in[gi] ^ pol;
				oe_d = steer_q[gi] & ~hold;
				if (sd_q)
				begin
					o_d  = (pss == `CCO_PSS_ACTIVE) ^ pol;
					oe_d = steer_q[gi] & pss[1];
				end
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					o_q  <= 1'b0;
					oe_q <= 1'b0;
				end
				else
				begin
					o_q  <= o_d;
					oe_q <= oe_d;
				end
			end
			assign oc_o[gi]  = o_q;
			assign oc_oe[gi] = oe_q;
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (sel[0])
			prdata = gate_q;
		else if (sel[1])
			prdata = mode_q;
		else if (sel[2])
		begin
			prdata[`CCO_B_TRIG]  = timer_triggered;
			prdata[`CCO_B_SHUTDOWN_ACTIVE_FLAG] = sd_q;
			prdata[`CCO_B_CAPTURE_DISABLE_FLAG] = capture_disable_flag_q;
		end
	end

endmodule : cco_output_ctrl

// File: verification/capture_compare_output_control_tb.sv
`timescale 1ns/1ps
module capture_compare_output_control_tb;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic        err;
	} cco_row_t;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, tb_rollover = 1'h0, one_shot_trigger = 1'h0;
	logic        triggered_operation_enable = 1'h0, timer_triggered = 1'h0;
	logic        timer_mode = 1'h0, mode_signal = 1'h0, compare_event = 1'h0;
	logic        capture_input_pin = 1'h0, aux_out, capture_event, one_shot_active;
	logic        shutdown_active_flag, capture_disable_flag;
	logic [5:0]  pwm_in = 6'h0, pin_steer_enables, oc_o, oc_oe, pin_level;
	logic [2:0]  cmp_in = 3'h0, output_mode_select;
	logic [3:0]  clc_in = 4'h0;
	cco_pkg::cco_gate_src_t gate_src = '0;
	int          failures = 0, num_checks = 0, k;
	cco_row_t    rows [4] = '{'{12'h000, 32'hffbf_ffff, 32'hbf9f_d0ff, 1'h0},
		'{12'h004, 32'hfeff_ffff, 32'hf63f_003f, 1'h0}, '{12'h00c, 32'h1, 32'h0, 1'h1},
		'{12'h000, 32'h0, 32'h0, 1'h0}};
	cco_output_ctrl u_cco_output_ctrl (.*);
	cco_load_model u_cco_load_model (.pclk(pclk), .drv(oc_o), .drv_en(oc_oe), .pin_level(pin_level));
	always #5 pclk = ~pclk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task tick(input int c);
		repeat (c) @(posedge pclk);
	endtask : tick
	task roll;
		tb_rollover <= 1'h1;
		tick(1);
		tb_rollover <= 1'h0;
		tick(1);
	endtask : roll
	task wflag(input logic v);
		int m;
		m = 0;
		while (shutdown_active_flag !== v && m < 20)
		begin
			tick(1);
			m++;
		end
		chk(shutdown_active_flag, v);
		if (m == 20)
			print_verdict();
	endtask : wflag
	// held until the edge that samples pready high, then released
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int m;
		tick(1);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'h1;
		m = 0;
		do
		begin
			tick(1);
			m++;
		end while (pready !== 1'h1 && m < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (m == 20)
		begin
			failures++;
			print_verdict();
		end
	endtask : apb
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		tick(10);
		presetn <= 1'h1;
		foreach (rows[i])
		begin
			apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
			chk(err, rows[i].err);
		end
		$display("end rows");
		presetn <= 1'h0;
		tick(2);
		presetn <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h0100_0000);
		chk(pin_steer_enables, 6'h01);
		for (k = 0; k < 7; k++)
			if (k != 3)
			begin
				apb(1'h1, 12'h004, k << 24);
				tick(1);
				chk(output_mode_select, k);
			end
		apb(1'h1, 12'h004, 32'h000c_0000);
		for (k = 0; k < 8; k++)
		begin
			apb(1'h1, 12'h000, 32'h0100_0000 | (1 << k));
			gate_src <= cco_pkg::cco_gate_src_t'(~(8'h1 << k));
			tick(4);
			chk(shutdown_active_flag, 1'h0);
			gate_src <= cco_pkg::cco_gate_src_t'(8'h1 << k);
			wflag(1'h1);
			tick(2);
			chk({oc_oe[0], oc_o[0]}, 2'h3);
			gate_src <= '0;
			apb(1'h1, 12'h008, 32'h10);
			wflag(1'h0);
		end
		$display("end sources");
		apb(1'h1, 12'h000, 32'h0100_4001);
		gate_src <= cco_pkg::cco_gate_src_t'(8'h1);
		tick(5);
		chk(shutdown_active_flag, 1'h0);
		roll();
		wflag(1'h1);
		apb(1'h1, 12'h000, 32'h0100_8001);
		gate_src <= '0;
		tick(4);
		chk(shutdown_active_flag, 1'h1);
		roll();
		wflag(1'h0);
		apb(1'h1, 12'h000, 32'h0100_1000);
		wflag(1'h1);
		apb(1'h1, 12'h000, 32'h0300_0000);
		apb(1'h1, 12'h008, 32'h10);
		wflag(1'h0);
		$display("end shutdown");
		pwm_in <= 6'h03;
		apb(1'h1, 12'h004, 32'h0);
		tick(3);
		chk(pin_level[1:0], 2'h3);
		apb(1'h1, 12'h004, 32'h0030_0000);
		tick(3);
		chk(pin_level[1:0], 2'h0);
		apb(1'h1, 12'h000, 32'h8400_0000);
		tick(3);
		chk(pin_steer_enables, 6'h03);
		roll();
		tick(2);
		chk(pin_steer_enables, 6'h04);
		apb(1'h1, 12'h004, 32'h8000_0000);
		triggered_operation_enable <= 1'h1;
		tick(3);
		chk(oc_oe, 6'h00);
		timer_triggered <= 1'h1;
		tick(3);
		chk(oc_oe, 6'h04);
		$display("end outputs");
		apb(1'h1, 12'h004, 32'h2000_0000);
		one_shot_trigger <= 1'h1;
		tick(1);
		one_shot_trigger <= 1'h0;
		tick(1);
		chk(one_shot_active, 1'h1);
		for (k = 0; one_shot_active === 1'h1 && k < 12; k++)
			roll();
		chk(k, 3);
		apb(1'h1, 12'h000, 32'h0);
		tick(3);
		chk(capture_disable_flag, 1'h1);
		apb(1'h1, 12'h000, 32'h0000_1000);
		tick(3);
		chk(capture_disable_flag, 1'h0);
		capture_input_pin <= 1'h1;
		for (k = 0; capture_event !== 1'h1 && k < 6; k++)
			tick(1);
		chk(capture_event, 1'h1);
		$display("end timing");
		apb(1'h1, 12'h000, 32'h0008_0000);
		roll();
		chk(aux_out, 1'h1);
		tick(1);
		chk(aux_out, 1'h0);
		apb(1'h1, 12'h000, 32'h0018_0000);
		compare_event <= 1'h1;
		tick(1);
		compare_event <= 1'h0;
		tick(1);
		chk(aux_out, 1'h1);
		timer_mode <= 1'h1;
		compare_event <= 1'h1;
		tick(1);
		compare_event <= 1'h0;
		tick(1);
		chk(aux_out, 1'h0);
		apb(1'h1, 12'h000, 32'h0010_0000);
		mode_signal <= 1'h1;
		tick(2);
		chk(aux_out, 1'h1);
		$display("end aux");
		// rising-edge gating ignores the gate until armed
		apb(1'h1, 12'h000, 32'h0041_0001);
		gate_src <= cco_pkg::cco_gate_src_t'(8'h01);
		tick(4);
		chk(capture_disable_flag, 1'h1);
		gate_src <= '0;
		apb(1'h1, 12'h008, 32'h0000_0400);
		gate_src <= cco_pkg::cco_gate_src_t'(8'h01);
		tick(4);
		chk(capture_disable_flag, 1'h0);
		cmp_in <= 3'h1;
		for (k = 0; capture_event !== 1'h1 && k < 6; k++)
			tick(1);
		chk(capture_event, 1'h1);
		apb(1'h1, 12'h000, 32'h0100_0000);
		apb(1'h1, 12'h004, 32'h0008_0000);
		tick(3);
		chk({oc_oe[0], oc_o[0]}, 2'h2);
		apb(1'h1, 12'h004, 32'h0);
		tick(3);
		chk(oc_oe, 6'h00);
		apb(1'h0, 12'h008, 32'h0);
		chk(rd, 32'h0000_0094);
		$display("end gating");
		print_verdict();
	end
endmodule : capture_compare_output_control_tb

// File: verification/cco_load_model.sv
`timescale 1ns/1ps
// power-stage loads: no pull on the pins, so a released pin toggles
// every cycle instead of keeping the last driven level
module cco_load_model #(
	parameter int NPINS = 6
) (
	input wire logic             pclk,
	input wire logic [NPINS-1:0] drv,
	input wire logic [NPINS-1:0] drv_en,
	output logic     [NPINS-1:0] pin_level
);
	logic [NPINS-1:0] last_q = '0;
	always_ff @(posedge pclk)
	begin
		last_q <= pin_level;
	end
	assign pin_level = (drv & drv_en) | (~last_q & ~drv_en);
endmodule : cco_load_model

// File: verification/cco_output_ctrl_checker.sv
`timescale 1ns/1ps
module cco_output_ctrl_checker #(
	parameter int NPINS = 6
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [11:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pslverr,
	input wire logic             tb_rollover,
	input wire logic             one_shot_trigger,
	input wire logic [NPINS-1:0] pin_steer_enables,
	input wire logic [NPINS-1:0] oc_oe,
	input wire logic             capture_event,
	input wire logic             one_shot_active,
	input wire logic [2:0]       output_mode_select,
	input wire logic             shutdown_active_flag,
	input wire logic             capture_disable_flag
);
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic       acc;
	logic [3:0] roll_cnt_q;
	logic [3:0] roll_cnt_d;
	assign acc = psel && penable;
	// rollovers seen while the one-shot runs; a counter, since repetition must stay short
	always_comb
	begin
		roll_cnt_d = one_shot_active ? roll_cnt_q + {3'h0, tb_rollover} : 4'h0;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			roll_cnt_q <= 4'h0;
		else
			roll_cnt_q <= roll_cnt_d;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_unmapped;
		acc && !(paddr inside {12'h000, 12'h004, 12'h008}) |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_gate_rsvd;
		acc && !pwrite && paddr == 12'h000 |-> (prdata & 32'h4020_2f00) == 32'h0;
	endproperty
	a_gate_rsvd: assert property (p_gate_rsvd) else $error("gate reg spare bits set");
	property p_mode_rsvd;
		acc && !pwrite && paddr == 12'h004 |-> (prdata & 32'h08c0_ffc0) == 32'h0;
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode reg spare bits set");
	property p_steer_off;
		(oc_oe & ~pin_steer_enables & ~$past(pin_steer_enables)) == '0;
	endproperty
	a_steer_off: assert property (p_steer_off) else $error("released pin still driven");
	property p_cap_block;
		capture_event |-> !$past(capture_disable_flag);
	endproperty
	a_cap_block: assert property (p_cap_block) else $error("capture while disabled");
	property p_os_start;
		$rose(one_shot_active) |-> $past(one_shot_trigger);
	endproperty
	a_os_start: assert property (p_os_start) else $error("one-shot without trigger");
	property p_os_len;
		roll_cnt_q <= 4'h8;
	endproperty
	a_os_len: assert property (p_os_len) else $error("one-shot beyond eight periods");
	property p_mode_fld;
		$changed(output_mode_select) |-> $past(acc && pwrite && paddr == 12'h004)
			&& output_mode_select == $past(pwdata[26:24]);
	endproperty
	a_mode_fld: assert property (p_mode_fld) else $error("mode field changed unasked");
	property p_flag_clr;
		$fell(shutdown_active_flag) |-> $past(tb_rollover)
			|| $past(acc && pwrite && paddr == 12'h008 && pwdata[4]);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("shutdown flag cleared early");
endmodule : cco_output_ctrl_checker

bind cco_output_ctrl cco_output_ctrl_checker #(.NPINS(NPINS)) u_cco_output_ctrl_checker (.*);
